/* bench/sbst_host_model.sv */
// Board test controller model driving the scan pins of the test port
`timescale 1ns/1ps
module sbst_host_model (
    // System clock paces the pins and records the last driven data-out level
    input wire logic clk,
    // Scan pins
    output logic testClk,
    output logic modeSel,
    output logic dataIn,
    input wire logic dataOut,
    input wire logic dataOutEn
);
    logic lastOut = 1'b0;
    logic wireOut;

    // Released data-out has no pull, so it reads the inverse level
    assign wireOut = dataOutEn ? dataOut : ~lastOut;
    always @(posedge clk) begin
        if (dataOutEn) begin
            lastOut <= dataOut;
        end
    end

    // Clock parked low while idle, pulled-up pins read high
    initial begin
        testClk = 1'b0;
        modeSel = 1'b1;
        dataIn = 1'b1;
    end

    // One 160 ns test-clock period, entered and left at a falling edge
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        modeSel = tms;
        dataIn = tdi;
        repeat (4) @(negedge clk);
        tdo = wireOut;
        testClk = 1'b1;
        repeat (4) @(negedge clk);
        testClk = 1'b0;
    endtask

    // Five high mode-select edges, then park in Run-Test/Idle
    task automatic reset_idle();
        logic b;
        repeat (5) step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask

    // Capture then shift n bits LSB first, ending in Exit1
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic b;
        dout = '0;
        step(1'b1, 1'b1, b);
        if (ir) begin
            step(1'b1, 1'b1, b);
        end
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
    endtask

    // Pause, come back through Exit2, shift n more bits, end in Exit1
    task automatic resume(input int n, input logic [63:0] din,
                          output logic [63:0] dout);
        logic b;
        dout = '0;
        step(1'b0, 1'b1, b);
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], b);
            dout[i] = b;
        end
    endtask

    // Update, then two idle periods so the new outputs settle
    task automatic finish();
        logic b;
        step(1'b1, 1'b1, b);
        step(1'b0, 1'b1, b);
        step(1'b0, 1'b1, b);
    endtask
endmodule // sbst_host_model

/* bench/tb_sbst_tap.sv */
// Self-checking bench for the SRAM boundary-scan test port
`timescale 1ns/1ps
module tb_sbst_tap;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic testClk, modeSel, dataIn, dataOut, dataOutEn, memOutHiZ;
    logic [sbst_pkg::BSR_W-1:0] pinRing = '0;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;
    int seed = 99;
    // Reserved codes are never loaded
    logic [2:0] codes [5] = '{sbst_pkg::INS_EXTEST,
        sbst_pkg::INS_IDREAD, sbst_pkg::INS_SAMPLEZ, sbst_pkg::INS_SAMPLE,
        sbst_pkg::INS_BYPASS};
    logic hizOld = 1'b0;

    sbst_tap uut (.clk(clk), .arst_n(arst_n), .testClk(testClk),
        .modeSel(modeSel), .dataIn(dataIn), .dataOut(dataOut),
        .dataOutEn(dataOutEn), .pinRing(pinRing), .memOutHiZ(memOutHiZ));
    sbst_host_model host (.clk(clk), .testClk(testClk), .modeSel(modeSel),
        .dataIn(dataIn), .dataOut(dataOut), .dataOutEn(dataOutEn));

    // 50 MHz system clock
    always #10 clk = ~clk;

    // Hang guard, well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask

    // Data-register length selected by an instruction
    function automatic int dr_len(input logic [2:0] code);
        case (code)
            sbst_pkg::INS_IDREAD: return sbst_pkg::ID_W;
            sbst_pkg::INS_BYPASS: return 1;
            default: return sbst_pkg::BSR_W;
        endcase
    endfunction

    // Outputs forced off only by the two high-Z codes
    function automatic logic hiz_exp(input logic [2:0] code);
        return code == sbst_pkg::INS_EXTEST || code == sbst_pkg::INS_SAMPLEZ;
    endfunction

    // Captured value first, then the bits fed in at the MSB
    function automatic logic [63:0] dr_exp(input logic [2:0] code,
            input logic [63:0] din, input logic [63:0] ring);
        logic [63:0] cap;
        int len;
        len = dr_len(code);
        case (code)
            sbst_pkg::INS_IDREAD: cap = {32'h0, sbst_pkg::ID_CODE};
            sbst_pkg::INS_BYPASS: cap = 64'h0;
            default: cap = ring;
        endcase
        return (cap | (din << len)) & ((64'h1 << (len + 8)) - 64'h1);
    endfunction

    // Scan the selected data register with eight extra random bits
    task automatic dr_check(input logic [2:0] code);
        logic [63:0] din;
        logic [63:0] dout;
        din = {$random(seed), $random(seed)};
        host.scan(1'b0, dr_len(code) + 8, din, dout);
        check(dout, dr_exp(code, din, 64'(pinRing)));
        check(dataOutEn, 1'b1);
        host.finish();
        check(dataOutEn, 1'b0);
        check(memOutHiZ, hizOld);
    endtask

    // Pause mid-scan, resume through Exit2 and read back what went in
    task automatic pause_check(input logic [2:0] code);
        logic [63:0] din;
        logic [63:0] dout;
        int len;
        len = dr_len(code);
        din = {$random(seed), $random(seed)};
        host.scan(1'b0, len, din, dout);
        check(dout, dr_exp(code, 64'h0, 64'(pinRing)));
        host.resume(len, 64'h0, dout);
        check(dout, din & ((64'h1 << len) - 64'h1));
        check(dataOutEn, 1'b1);
        host.finish();
        check(dataOutEn, 1'b0);
        check(memOutHiZ, hizOld);
    endtask

    // Load an instruction; old one must stay active until the update
    task automatic ir_load(input logic [2:0] code);
        logic [63:0] din;
        logic [63:0] dout;
        din = {$random(seed), $random(seed)};
        din[2:0] = code;
        host.scan(1'b1, 3, din, dout);
        check(dout[1:0], 2'h1);
        check(memOutHiZ, hizOld);
        host.finish();
        hizOld = hiz_exp(code);
        check(memOutHiZ, hizOld);
    endtask

    // Main sequence
    initial begin
        logic b;
        logic [2:0] code;
        repeat (16) @(posedge clk);
        @(negedge clk);
        arst_n = 1'b1;
        check(dataOutEn, 1'b0);
        check(memOutHiZ, 1'b0);
        repeat (4) @(negedge clk);
        // Power-up instruction is the identification read
        host.step(1'b0, 1'b1, b);
        dr_check(sbst_pkg::INS_IDREAD);
        // Every legal code in turn, then random picks
        for (int i = 0; i < 12; i++) begin
            code = (i < 5) ? codes[i] : codes[$unsigned($random(seed)) % 5];
            pinRing = sbst_pkg::BSR_W'({$random(seed), $random(seed)});
            ir_load(code);
            dr_check(code);
        end
        // Five high edges drop a high-Z instruction back to the id read
        ir_load(sbst_pkg::INS_EXTEST);
        host.reset_idle();
        hizOld = 1'b0;
        check(memOutHiZ, 1'b0);
        dr_check(sbst_pkg::INS_IDREAD);
        // Pause and resume mid-scan; contents survive, pins stay put
        ir_load(sbst_pkg::INS_SAMPLE);
        pause_check(sbst_pkg::INS_SAMPLE);
        give_verdict();
    end
endmodule // tb_sbst_tap

/* hdl/sbst_pkg.sv */
// Package: constants and types for the SRAM boundary-scan test port
package sbst_pkg;

    // Instruction codes
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDREAD = 3'h1;
    localparam logic [2:0] INS_SAMPLEZ = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;
    localparam logic [2:0] IR_RESET = INS_IDREAD;
    localparam logic [1:0] IR_CAPT = 2'h1;

    // Register widths
    localparam int IR_W = 3;
    localparam int ID_W = 32;
    localparam int BSR_W = 51;

    // Identification code fields; vendor field is arbitrary
    localparam logic [3:0] ID_REV = 4'h0;
    localparam logic [4:0] ID_DEPTH = 5'h07;
    localparam logic [4:0] ID_WIDTH = 5'h04;
    localparam logic [5:0] ID_PART = 6'h00;
    localparam logic [10:0] ID_VENDOR = 11'h2A5;
    localparam logic [31:0] ID_CODE = {ID_REV, ID_DEPTH, ID_WIDTH, ID_PART,
                                       ID_VENDOR, 1'b1};

    // Consecutive high mode-select edges that force reset
    localparam logic [2:0] RESET_EDGES = 3'h5;

    // Test-access controller states
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SELDR = 4'h2, ST_CAPDR = 4'h3,
        ST_SHDR = 4'h4, ST_EX1DR = 4'h5, ST_PAUDR = 4'h6, ST_EX2DR = 4'h7,
        ST_UPDR = 4'h8, ST_SELIR = 4'h9, ST_CAPIR = 4'hA, ST_SHIR = 4'hB,
        ST_EX1IR = 4'hC, ST_PAUIR = 4'hD, ST_EX2IR = 4'hE, ST_UPIR = 4'hF
    } sbst_state_t;

endpackage

/* hdl/sbst_sync.sv */
// Two-stage synchroniser for pins entering the system clock domain
`timescale 1ns/1ps
module sbst_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] stage1_r;
    logic [W-1:0] stage2_r;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_r <= INIT;
            stage2_r <= INIT;
        end else begin
            stage1_r <= d;
            stage2_r <= stage1_r;
        end
    end

    assign q = stage2_r;
endmodule // sbst_sync

/* hdl/sbst_tap.sv */
// Boundary-scan test port: controller, instruction and data registers
// Operation
// - Inputs sampled on rising test clock; outputs change on falling edge.
// - Mode select steers controller each rising edge; unconnected reads high.
// - Data-in feeds MSB of selected register; unconnected reads high.
// - Data-out shows LSB of selected register, updated on falling edges.
// - Power-up reset leaves data-out undriven; driven only while shifting.
// - Five high mode-select edges reset the controller, memory unaffected.
// - Exactly one register, picked by instruction, sits in the scan path.
// - Three-bit instruction register shifts during Shift-IR.
// - New instruction takes effect only at Update-IR.
// - Instruction resets to identification read at power-up and reset.
// - Capture-IR loads pattern 01 into the two low bits.
// - One-bit bypass cleared by bypass instruction, shifts in Shift-DR.
// - Boundary register snapshots pins at Capture-DR, shifts in Shift-DR.
// - All-zeros instruction acts as sample but forces outputs high-Z.
// - Sample-high-Z shifts boundary register and forces outputs high-Z.
// - Identification instruction captures hardwired 32-bit code.
// - No preload; Update-DR under sample changes nothing.
// - Port never drives memory values; boundary cells only capture.
// - Code 001 selects identification register.
// - Code 100 selects sample, capturing pins, memory unaffected.
// - Code 111 selects the bypass register.
// - Codes 000 and 010 select boundary register and force high-Z.
`timescale 1ns/1ps
module sbst_tap (
    // System clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Test pins from the board controller
    input wire logic testClk,
    input wire logic modeSel,
    input wire logic dataIn,
    // Serial data out, three-state form as data plus enable
    output logic dataOut,
    output logic dataOutEn,
    // Memory pin ring to capture
    input wire logic [sbst_pkg::BSR_W-1:0] pinRing,
    // Memory output drivers forced off
    output logic memOutHiZ
);
    logic tckS, tmsS, tdiS;
    logic tckPrev_r, tckPrev_nxt;
    logic rise, fall;
    sbst_pkg::sbst_state_t state_r, state_nxt;
    logic [sbst_pkg::IR_W-1:0] irShift_r, irShift_nxt;
    logic [sbst_pkg::IR_W-1:0] instr_r, instr_nxt;
    logic bypass_r, bypass_nxt;
    logic [sbst_pkg::ID_W-1:0] idShift_r, idShift_nxt;
    logic [sbst_pkg::BSR_W-1:0] bsr_r, bsr_nxt;
    logic [sbst_pkg::BSR_W-1:0] ringS;
    logic [2:0] highCnt_r, highCnt_nxt;
    logic dataOut_r, dataOut_nxt;
    logic dataOutEn_r, dataOutEn_nxt;
    logic hiZ_r, hiZ_nxt;
    logic selBsr, selId, serialLsb;

    // Pins reach logic only through two flops; pull-ups modeled as reset 1
    sbst_sync #(.W(3), .INIT(3'h3)) uSyncPins (
        .clk(clk), .arst_n(arst_n),
        .d({testClk, modeSel, dataIn}), .q({tckS, tmsS, tdiS})
    );
    // Ring is sampled slowly; values that toggle at capture are not assured
    sbst_sync #(.W(sbst_pkg::BSR_W)) uSyncRing (
        .clk(clk), .arst_n(arst_n), .d(pinRing), .q(ringS)
    );

    // Edge detection of the test clock
    assign rise = tckS & ~tckPrev_r;
    assign fall = ~tckS & tckPrev_r;
    assign tckPrev_nxt = tckS;

    // Register routing by instruction; reserved codes fall to bypass
    always_comb begin
        selBsr = (instr_r == sbst_pkg::INS_EXTEST) ||
                 (instr_r == sbst_pkg::INS_SAMPLEZ) ||
                 (instr_r == sbst_pkg::INS_SAMPLE);
        selId = (instr_r == sbst_pkg::INS_IDREAD);
        if (state_r == sbst_pkg::ST_SHIR) begin
            serialLsb = irShift_r[0];
        end else if (selId) begin
            serialLsb = idShift_r[0];
        end else if (selBsr) begin
            serialLsb = bsr_r[0];
        end else begin
            serialLsb = bypass_r;
        end
    end

    // Controller next state, advancing on rising test-clock edges
    always_comb begin
        state_nxt = state_r;
        highCnt_nxt = highCnt_r;
        if (rise) begin
            highCnt_nxt = tmsS ? ((highCnt_r == sbst_pkg::RESET_EDGES) ?
                          highCnt_r : highCnt_r + 3'h1) : 3'h0;
            unique case (state_r)
                sbst_pkg::ST_RESET: state_nxt = tmsS ? sbst_pkg::ST_RESET
                                                     : sbst_pkg::ST_IDLE;
                sbst_pkg::ST_IDLE: state_nxt = tmsS ? sbst_pkg::ST_SELDR
                                                    : sbst_pkg::ST_IDLE;
                sbst_pkg::ST_SELDR: state_nxt = tmsS ? sbst_pkg::ST_SELIR
                                                     : sbst_pkg::ST_CAPDR;
                sbst_pkg::ST_CAPDR: state_nxt = tmsS ? sbst_pkg::ST_EX1DR
                                                     : sbst_pkg::ST_SHDR;
                sbst_pkg::ST_SHDR: state_nxt = tmsS ? sbst_pkg::ST_EX1DR
                                                    : sbst_pkg::ST_SHDR;
                sbst_pkg::ST_EX1DR: state_nxt = tmsS ? sbst_pkg::ST_UPDR
                                                     : sbst_pkg::ST_PAUDR;
                sbst_pkg::ST_PAUDR: state_nxt = tmsS ? sbst_pkg::ST_EX2DR
                                                     : sbst_pkg::ST_PAUDR;
                sbst_pkg::ST_EX2DR: state_nxt = tmsS ? sbst_pkg::ST_UPDR
                                                     : sbst_pkg::ST_SHDR;
                sbst_pkg::ST_UPDR: state_nxt = tmsS ? sbst_pkg::ST_SELDR
                                                    : sbst_pkg::ST_IDLE;
                sbst_pkg::ST_SELIR: state_nxt = tmsS ? sbst_pkg::ST_RESET
                                                     : sbst_pkg::ST_CAPIR;
                sbst_pkg::ST_CAPIR: state_nxt = tmsS ? sbst_pkg::ST_EX1IR
                                                     : sbst_pkg::ST_SHIR;
                sbst_pkg::ST_SHIR: state_nxt = tmsS ? sbst_pkg::ST_EX1IR
                                                    : sbst_pkg::ST_SHIR;
                sbst_pkg::ST_EX1IR: state_nxt = tmsS ? sbst_pkg::ST_UPIR
                                                     : sbst_pkg::ST_PAUIR;
                sbst_pkg::ST_PAUIR: state_nxt = tmsS ? sbst_pkg::ST_EX2IR
                                                     : sbst_pkg::ST_PAUIR;
                sbst_pkg::ST_EX2IR: state_nxt = tmsS ? sbst_pkg::ST_UPIR
                                                     : sbst_pkg::ST_SHIR;
                sbst_pkg::ST_UPIR: state_nxt = tmsS ? sbst_pkg::ST_SELDR
                                                    : sbst_pkg::ST_IDLE;
            endcase
            // Redundant with the graph, but kept as an explicit guarantee
            if (tmsS && highCnt_r >= sbst_pkg::RESET_EDGES - 3'h1) begin
                state_nxt = sbst_pkg::ST_RESET;
            end
        end
    end

    // Shift registers: capture, shift, update; all on rising edges
    always_comb begin
        irShift_nxt = irShift_r;
        instr_nxt = instr_r;
        bypass_nxt = bypass_r;
        idShift_nxt = idShift_r;
        bsr_nxt = bsr_r;
        if (rise) begin
            unique case (state_r)
                sbst_pkg::ST_RESET: instr_nxt = sbst_pkg::IR_RESET;
                sbst_pkg::ST_CAPIR: irShift_nxt = {
                    irShift_r[sbst_pkg::IR_W-1], sbst_pkg::IR_CAPT};
                sbst_pkg::ST_SHIR: irShift_nxt = {tdiS,
                    irShift_r[sbst_pkg::IR_W-1:1]};
                sbst_pkg::ST_UPIR: instr_nxt = irShift_r;
                sbst_pkg::ST_CAPDR: begin
                    if (selId) begin
                        idShift_nxt = sbst_pkg::ID_CODE;
                    end else if (selBsr) begin
                        bsr_nxt = ringS;
                    end else begin
                        bypass_nxt = 1'b0;
                    end
                end
                sbst_pkg::ST_SHDR: begin
                    if (selId) begin
                        idShift_nxt = {tdiS,
                                       idShift_r[sbst_pkg::ID_W-1:1]};
                    end else if (selBsr) begin
                        bsr_nxt = {tdiS, bsr_r[sbst_pkg::BSR_W-1:1]};
                    end else begin
                        bypass_nxt = tdiS;
                    end
                end
                // Update-DR and pauses leave contents alone: no preload
                default: bsr_nxt = bsr_r;
            endcase
        end
    end

    // Outputs move only on falling edges
    always_comb begin
        dataOut_nxt = dataOut_r;
        dataOutEn_nxt = dataOutEn_r;
        hiZ_nxt = hiZ_r;
        if (fall) begin
            dataOut_nxt = serialLsb;
            dataOutEn_nxt = (state_r == sbst_pkg::ST_SHDR) ||
                            (state_r == sbst_pkg::ST_SHIR);
            hiZ_nxt = (instr_r == sbst_pkg::INS_EXTEST) ||
                      (instr_r == sbst_pkg::INS_SAMPLEZ);
        end
    end

    // State registers; reset state mirrors power-up self reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tckPrev_r <= 1'b0;
            state_r <= sbst_pkg::ST_RESET;
            highCnt_r <= 3'h0;
            irShift_r <= sbst_pkg::IR_RESET;
            instr_r <= sbst_pkg::IR_RESET;
            bypass_r <= 1'b0;
            idShift_r <= sbst_pkg::ID_CODE;
            bsr_r <= '0;
            dataOut_r <= 1'b0;
            dataOutEn_r <= 1'b0;
            hiZ_r <= 1'b0;
        end else begin
            tckPrev_r <= tckPrev_nxt;
            state_r <= state_nxt;
            highCnt_r <= highCnt_nxt;
            irShift_r <= irShift_nxt;
            instr_r <= instr_nxt;
            bypass_r <= bypass_nxt;
            idShift_r <= idShift_nxt;
            bsr_r <= bsr_nxt;
            dataOut_r <= dataOut_nxt;
            dataOutEn_r <= dataOutEn_nxt;
            hiZ_r <= hiZ_nxt;
        end
    end

    assign dataOut = dataOut_r;
    assign dataOutEn = dataOutEn_r;
    assign memOutHiZ = hiZ_r;

    // Checks
    property p_out_on_fall;
        @(posedge clk) disable iff (!arst_n)
        !fall |=> $stable(dataOut_r) && $stable(dataOutEn_r);
    endproperty
    a_out_on_fall: assert property (p_out_on_fall)
        else $error("data-out moved without a falling edge");

    property p_five_high;
        @(posedge clk) disable iff (!arst_n)
        rise && tmsS && highCnt_r == sbst_pkg::RESET_EDGES - 3'h1 |=>
            state_r == sbst_pkg::ST_RESET;
    endproperty
    a_five_high: assert property (p_five_high)
        else $error("five high mode edges did not reset");

    property p_reset_instr;
        @(posedge clk) disable iff (!arst_n)
        rise && state_r == sbst_pkg::ST_RESET |=>
            instr_r == sbst_pkg::INS_IDREAD;
    endproperty
    a_reset_instr: assert property (p_reset_instr)
        else $error("instruction not restored at reset");

    property p_cap_ir;
        @(posedge clk) disable iff (!arst_n)
        rise && state_r == sbst_pkg::ST_CAPIR |=>
            irShift_r[1:0] == sbst_pkg::IR_CAPT;
    endproperty
    a_cap_ir: assert property (p_cap_ir)
        else $error("capture pattern missing");

    property p_instr_upd;
        @(posedge clk) disable iff (!arst_n)
        $changed(instr_r) |-> $past(state_r) inside
            {sbst_pkg::ST_UPIR, sbst_pkg::ST_RESET};
    endproperty
    a_instr_upd: assert property (p_instr_upd)
        else $error("instruction changed outside update");

    property p_en_shift;
        @(posedge clk) disable iff (!arst_n)
        dataOutEn_r |-> state_r inside {sbst_pkg::ST_SHDR, sbst_pkg::ST_SHIR,
            sbst_pkg::ST_EX1DR, sbst_pkg::ST_EX1IR};
    endproperty
    a_en_shift: assert property (p_en_shift)
        else $error("data-out driven outside shifting");

    property p_id_cap;
        @(posedge clk) disable iff (!arst_n)
        rise && state_r == sbst_pkg::ST_CAPDR && selId |=>
            idShift_r == sbst_pkg::ID_CODE;
    endproperty
    a_id_cap: assert property (p_id_cap)
        else $error("identification code not captured");

    property p_hiz;
        @(posedge clk) disable iff (!arst_n)
        fall && instr_r == sbst_pkg::INS_SAMPLE |=> !memOutHiZ;
    endproperty
    a_hiz: assert property (p_hiz)
        else $error("sample forced outputs off");

    property p_bypass_clr;
        @(posedge clk) disable iff (!arst_n)
        rise && state_r == sbst_pkg::ST_CAPDR &&
            instr_r == sbst_pkg::INS_BYPASS |=> !bypass_r;
    endproperty
    a_bypass_clr: assert property (p_bypass_clr)
        else $error("bypass not cleared");

    c_shift_dr: cover property (@(posedge clk) state_r == sbst_pkg::ST_SHDR);
    c_upd_ir: cover property (@(posedge clk) state_r == sbst_pkg::ST_UPIR);
    c_hiz: cover property (@(posedge clk) memOutHiZ);
    c_pause_dr: cover property (@(posedge clk) state_r == sbst_pkg::ST_PAUDR);
endmodule // sbst_tap
